// ==== rtl/irq_clear_regs.svh ====
// constants for the change-interrupt block
`ifndef IRQ_CLEAR_REGS_SVH
`define IRQ_CLEAR_REGS_SVH
`define PORT_WIDTH 8
`define INPUT_REG_CMD 8'h00
`define CMD_RESET_VALUE 8'h00
`define PORT_RESET_VALUE 8'h00
`define SYNC_STAGES 3
`endif

// ==== rtl/irq_clear_pkg.sv ====
// shared types for the change-interrupt block
package irq_clear_pkg;
    // bus-side events seen by the block, one-cycle pulses
    typedef struct packed {
        logic input_read_done;
        logic cmd_write;
        logic [7:0] cmd_value;
        logic other_read_ack;
    } bus_event_type;

    typedef enum logic [1:0] {
        IRQ_IDLE,
        IRQ_PENDING
    } irq_state_type;
endpackage

// ==== rtl/port_sync.sv ====
// three-stage synchroniser for the port pins
`timescale 1ns/1ns
`include "irq_clear_regs.svh"
module port_sync #(
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync,
    output logic [WIDTH-1:0] pin_stable
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] stable_ff;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_ff <= WIDTH'(`PORT_RESET_VALUE);
            s2_ff <= WIDTH'(`PORT_RESET_VALUE);
            s3_ff <= WIDTH'(`PORT_RESET_VALUE);
        end
        else
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a bit only changes once stages two and three agree
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            stable_ff <= WIDTH'(`PORT_RESET_VALUE);
        else
            stable_ff <= (s2_ff & s3_ff) | (stable_ff & (s2_ff | s3_ff));
    end

    assign pin_sync = s3_ff;
    assign pin_stable = stable_ff;
endmodule // port_sync

// ==== rtl/change_irq.sv ====
// change-detect interrupt with its clearing conditions
`timescale 1ns/1ns
`include "irq_clear_regs.svh"
// What this block does
// - input register read clears the interrupt
// - inputs back to last read clear it
// - pointer 00h plus foreign read ack clears
// - pointer 00h counts without a following read
// - reset release puts everything at defaults
// - power-on reset is the only reset
module change_irq #(
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] port_pin,
    input wire irq_clear_pkg::bus_event_type bus_evt,
    output logic [WIDTH-1:0] input_value,
    output logic [7:0] cmd_pointer,
    output logic irq_n_o,
    output logic irq_n_oe_n
);
    // ==========================================
    // pin synchronisation
    logic [WIDTH-1:0] pins;
    logic [WIDTH-1:0] snap_ff;
    logic [WIDTH-1:0] in_ff;
    logic [7:0] cmd_ff;
    irq_clear_pkg::irq_state_type state_ff;
    irq_clear_pkg::irq_state_type nxt_state;
    logic differ;
    logic pointer_clear;
    logic changed;

    // ==========================================
    // pointer decode
    // the input register sits at pointer zero; the clear and its checks share this
    function automatic logic points_at_input(input logic [7:0] ptr);
        return ptr == `INPUT_REG_CMD;
    endfunction

    port_sync #(.WIDTH(WIDTH)) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pin_in(port_pin),
        .pin_sync(),
        .pin_stable(pins)
    );

    // ==========================================
    // snapshot and register pointer
    // arst_n is the power-on reset; nothing else resets this block
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            snap_ff <= WIDTH'(`PORT_RESET_VALUE);
        else if (bus_evt.input_read_done)
            snap_ff <= pins;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            in_ff <= WIDTH'(`PORT_RESET_VALUE);
        else
            in_ff <= pins;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cmd_ff <= `CMD_RESET_VALUE;
        else if (bus_evt.cmd_write)
            cmd_ff <= bus_evt.cmd_value;
    end

    // ==========================================
    // interrupt state
    assign differ = (pins != snap_ff);
    // a stored zero pointer counts even if no input read ever followed it
    assign pointer_clear = points_at_input(cmd_ff) && bus_evt.other_read_ack;
    // a fresh change must differ from both the previous sample and the snapshot, so a clear is not undone
    assign changed = (pins != in_ff) && differ;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            irq_clear_pkg::IRQ_IDLE:
            begin
                if (changed && !bus_evt.input_read_done)
                    nxt_state = irq_clear_pkg::IRQ_PENDING;
            end
            irq_clear_pkg::IRQ_PENDING:
            begin
                if (bus_evt.input_read_done || !differ || pointer_clear)
                    nxt_state = irq_clear_pkg::IRQ_IDLE;
            end
            default:
            begin
                nxt_state = irq_clear_pkg::IRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_ff <= irq_clear_pkg::IRQ_IDLE;
        else
            state_ff <= nxt_state;
    end

    // open drain: only ever pulls low, enable low while driving
    assign irq_n_o = 1'b0;
    assign irq_n_oe_n = (state_ff != irq_clear_pkg::IRQ_PENDING);
    assign input_value = in_ff;
    assign cmd_pointer = cmd_ff;

    // ==========================================
    // checks
    read_clears_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        bus_evt.input_read_done
        |=> irq_n_oe_n)
        else $error("interrupt stayed after input read");

    return_clears_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!differ && !changed)
        |=> irq_n_oe_n)
        else $error("interrupt stayed with inputs at snapshot");

    pointer_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pointer_clear
        |=> irq_n_oe_n)
        else $error("foreign read with pointer zero did not clear");

    pointer_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!irq_n_oe_n && bus_evt.other_read_ack && !points_at_input(cmd_ff)
        && !bus_evt.input_read_done && differ)
        |=> !irq_n_oe_n)
        else $error("foreign read with pointer off zero cleared");

    pointer_any_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (bus_evt.cmd_write && points_at_input(bus_evt.cmd_value))
        |=> points_at_input(cmd_ff))
        else $error("pointer zero not stored");

    pointer_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        bus_evt.cmd_write
        |=> cmd_pointer == $past(bus_evt.cmd_value))
        else $error("written pointer not stored");

    pointer_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !bus_evt.cmd_write
        |=> $stable(cmd_pointer))
        else $error("pointer moved without a write");

    change_sets_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (changed && !bus_evt.input_read_done && !pointer_clear)
        |=> !irq_n_oe_n)
        else $error("input change did not raise interrupt");

    idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (irq_n_oe_n && !changed)
        |=> irq_n_oe_n)
        else $error("interrupt raised without a fresh change");

    input_track_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'b1
        |=> input_value == $past(pins))
        else $error("input value does not follow the pins");

    snap_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        bus_evt.input_read_done
        |=> snap_ff == $past(pins))
        else $error("snapshot not taken on read");

    snap_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !bus_evt.input_read_done
        |=> $stable(snap_ff))
        else $error("snapshot moved without a read");

    reset_default_a: assert property (@(posedge sys_clk)
        $rose(arst_n)
        |-> irq_n_oe_n && cmd_pointer == `CMD_RESET_VALUE)
        else $error("defaults missing after reset");

    reset_snap_a: assert property (@(posedge sys_clk)
        $rose(arst_n)
        |-> snap_ff == '0 && input_value == '0)
        else $error("snapshot or input not cleared by reset");

    state_legal_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'b1
        |-> (state_ff == irq_clear_pkg::IRQ_IDLE || state_ff == irq_clear_pkg::IRQ_PENDING))
        else $error("interrupt state outside its legal set");

    // a return to the snapshot still shows one driven cycle, so look one sample back
    drive_low_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !irq_n_oe_n
        |-> $past(differ))
        else $error("interrupt driven without a difference");

    // ==========================================
    // cover points
    cover_raise_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(irq_n_oe_n));
    cover_keep_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        !irq_n_oe_n && bus_evt.other_read_ack && !points_at_input(cmd_ff));
    cover_read_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        !irq_n_oe_n ##1 bus_evt.input_read_done);
    cover_ptr_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        !irq_n_oe_n && pointer_clear);
    cover_back_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        !irq_n_oe_n && !differ);
endmodule // change_irq

// ==== test/bus_master_model.sv ====
// bus master model issuing one-clock bus events
`timescale 1ns/1ns
module bus_master_model (
    input wire logic sys_clk,
    output irq_clear_pkg::bus_event_type bus_evt
);
    // ====
    // event pulse
    initial bus_evt = '0;
    task automatic pulse(input irq_clear_pkg::bus_event_type e);
        @(posedge sys_clk);
        #1 bus_evt = e;
        @(posedge sys_clk);
        #1 bus_evt = '0;
    endtask
endmodule // bus_master_model

// ==== test/testbench.sv ====
// self-checking bench for the change-interrupt block
`timescale 1ns/1ns
module testbench;
    logic sys_clk;
    logic arst_n;
    logic [7:0] pin;
    irq_clear_pkg::bus_event_type bus_evt;
    logic [7:0] input_value;
    logic [7:0] cmd_pointer;
    logic irq_n_o;
    logic irq_n_oe_n;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    change_irq u_change_irq (.sys_clk(sys_clk), .arst_n(arst_n), .port_pin(pin),
        .bus_evt(bus_evt), .input_value(input_value), .cmd_pointer(cmd_pointer),
        .irq_n_o(irq_n_o), .irq_n_oe_n(irq_n_oe_n));
    bus_master_model u_bus_master_model (.sys_clk(sys_clk), .bus_evt(bus_evt));
    // ====
    // clock, checks and verdict
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 600)
        begin
            miscompares++;
            print_verdict();
        end
    end
    // ====
    // scenario helpers
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_reset();
        chk("irq_oe_n", 8'h01, {7'h00, irq_n_oe_n});
        chk("irq_data", 8'h00, {7'h00, irq_n_o});
        chk("pointer", 8'h00, cmd_pointer);
    endtask
    // 8 cycles covers the 4-cycle synchroniser plus the irq register
    task automatic set_pins(input logic [7:0] v, input logic e);
        pin = v;
        wait_clk(8);
        chk("irq_oe_n", {7'h00, e}, {7'h00, irq_n_oe_n});
    endtask
    task automatic ev_chk(input irq_clear_pkg::bus_event_type b, input logic e);
        u_bus_master_model.pulse(b);
        wait_clk(2);
        chk("irq_oe_n", {7'h00, e}, {7'h00, irq_n_oe_n});
    endtask
    // ====
    // main sequence
    initial
    begin
        arst_n = 1'b0;
        pin = 8'h00;
        repeat (2) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        t_reset();
        set_pins(8'h5A, 1'b0);
        chk("input", 8'h5A, input_value);
        ev_chk('{1'b1, 1'b0, 8'h00, 1'b0}, 1'b1);
        set_pins(8'h5B, 1'b0);
        set_pins(8'h5A, 1'b1);
        ev_chk('{1'b0, 1'b1, 8'h05, 1'b0}, 1'b1);
        ev_chk('{1'b0, 1'b1, 8'h00, 1'b0}, 1'b1);
        set_pins(8'hA5, 1'b0);
        ev_chk('{1'b0, 1'b0, 8'h00, 1'b1}, 1'b1);
        set_pins(8'h0F, 1'b0);
        ev_chk('{1'b0, 1'b1, 8'h05, 1'b0}, 1'b0);
        chk("pointer", 8'h05, cmd_pointer);
        ev_chk('{1'b0, 1'b0, 8'h00, 1'b1}, 1'b0);
        ev_chk('{1'b1, 1'b0, 8'h00, 1'b0}, 1'b1);
        set_pins(8'h3C, 1'b0);
        arst_n = 1'b0;
        wait_clk(1);
        t_reset();
        chk("input", 8'h00, input_value);
        arst_n = 1'b1;
        print_verdict();
    end
endmodule // testbench
